// ---- hmt_pkg.sv ----
// constants, encodings and carriers of the haptic mode and trigger control block
// assumes one 8-bit register port fed by the serial control bus engine
package hmt_pkg;

  // register addresses
  localparam logic [7:0] HMT_ADDR_STATUS = 8'h00;
  localparam logic [7:0] HMT_ADDR_MODE = 8'h01;
  localparam logic [7:0] HMT_ADDR_LIVE = 8'h02;
  localparam logic [7:0] HMT_ADDR_FIRE = 8'h0c;

  // field positions
  localparam int HMT_BIT_SRST = 7;
  localparam int HMT_BIT_STBY = 6;
  localparam int HMT_BIT_OUTCOME = 3;
  localparam int HMT_BIT_FIRE = 0;
  localparam int HMT_MODE_MSB = 2;

  // reset values
  localparam logic HMT_SRST_RST = 1'b0;
  localparam logic HMT_STBY_RST = 1'b1;
  localparam logic [7:0] HMT_LIVE_RST = 8'h00;
  localparam logic [7:0] HMT_RDATA_RST = 8'h00;
  localparam logic [8:0] HMT_LEVEL_IDLE = 9'h000;

  // operating modes, documented encodings
  typedef enum logic [2:0] {
    HMT_MODE_INT = 3'h0,
    HMT_MODE_EDGE = 3'h1,
    HMT_MODE_LEVEL = 3'h2,
    HMT_MODE_PWM = 3'h3,
    HMT_MODE_AUDIO = 3'h4,
    HMT_MODE_LIVE = 3'h5,
    HMT_MODE_DIAG = 3'h6,
    HMT_MODE_CAL = 3'h7
  } hmt_mode_e;

  // drive source handed to the output stage
  typedef enum logic [2:0] {
    HMT_SRC_NONE = 3'h0,
    HMT_SRC_LIBRARY = 3'h1,
    HMT_SRC_PWM = 3'h2,
    HMT_SRC_ANALOG = 3'h3,
    HMT_SRC_AUDIO = 3'h4,
    HMT_SRC_LIVE = 3'h5,
    HMT_SRC_DIAG = 3'h6,
    HMT_SRC_CAL = 3'h7
  } hmt_src_e;

  // one register access, at most one of wr and rd per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hmt_req_s;

  // read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hmt_rsp_s;

endpackage

// ---- hmt_trig_sync.sv ----
// trigger pin synchroniser with level and edge pulses
// assumes an asynchronous pin; all outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module hmt_trig_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // pin
  input wire logic pin_i,
  // synchronised view
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic level_d;
  logic rise_d;
  logic fall_d;

  always_comb begin
    level_d = sync_q;
    rise_d = sync_q & ~level_o;
    fall_d = ~sync_q & level_o;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      level_o <= level_d;
      rise_o <= rise_d;
      fall_o <= fall_d;
    end
  end
endmodule
`default_nettype wire

// ---- hmt_mode_ctrl.sv ----
// mode register, fire bit and trigger handling of a haptic actuator driver
// assumes a register port from the serial bus engine and a routine engine
// that reports completion of playback, diagnostic and calibration
`timescale 1ns/1ps
`default_nettype none
module hmt_mode_ctrl
  import hmt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register port
  input wire hmt_req_s req_i,
  output hmt_rsp_s rsp_o,
  // trigger pin and option bits held elsewhere
  input wire logic trigger_input_pin_i,
  input wire logic analog_select_i,
  input wire logic ac_coupling_enable_i,
  input wire logic live_value_signedness_i,
  // routine engine
  input wire logic routine_done_i,
  input wire logic routine_fail_i,
  // control towards the drive path
  output logic fire_o,
  output logic start_o,
  output logic cancel_o,
  output logic standby_o,
  output hmt_src_e drive_src_o,
  output logic [8:0] drive_level_o
);
  logic trig_level;
  logic trig_rise;
  logic trig_fall;

  logic srst_q, srst_d;
  logic stby_q, stby_d;
  hmt_mode_e mode_q, mode_d;
  logic [7:0] live_q, live_d;
  logic fire_q, fire_d;
  logic outcome_q, outcome_d;
  logic start_d, cancel_d;
  hmt_src_e src_d;
  logic [8:0] level_d;
  hmt_rsp_s rsp_d;

  logic wr_mode, wr_live, wr_fire, rd_status;
  logic routine_mode;

  hmt_trig_sync u_trig (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(trigger_input_pin_i),
    .level_o(trig_level),
    .rise_o(trig_rise),
    .fall_o(trig_fall)
  );

  always_comb begin
    wr_mode = req_i.wr && (req_i.addr == HMT_ADDR_MODE);
    wr_live = req_i.wr && (req_i.addr == HMT_ADDR_LIVE);
    wr_fire = req_i.wr && (req_i.addr == HMT_ADDR_FIRE);
    rd_status = req_i.rd && (req_i.addr == HMT_ADDR_STATUS);
    routine_mode = (mode_q == HMT_MODE_DIAG) || (mode_q == HMT_MODE_CAL);
  end

  // register and fire state
  always_comb begin
    srst_d = srst_q;
    stby_d = stby_q;
    mode_d = mode_q;
    live_d = live_q;
    fire_d = fire_q;
    outcome_d = outcome_q;
    start_d = 1'b0;
    cancel_d = 1'b0;
    if (srst_q) begin
      // acts like a power cycle: playback aborted, defaults restored
      srst_d = HMT_SRST_RST;
      stby_d = HMT_STBY_RST;
      mode_d = HMT_MODE_INT;
      live_d = HMT_LIVE_RST;
      fire_d = 1'b0;
      outcome_d = 1'b0;
      cancel_d = fire_q;
    end else begin
      if (rd_status) begin
        outcome_d = 1'b0;
      end
      if (wr_mode) begin
        srst_d = req_i.wdata[HMT_BIT_SRST];
        stby_d = req_i.wdata[HMT_BIT_STBY];
        mode_d = hmt_mode_e'(req_i.wdata[HMT_MODE_MSB:0]);
      end
      if (wr_live) begin
        live_d = req_i.wdata;
      end
      if (wr_fire) begin
        if (req_i.wdata[HMT_BIT_FIRE] && !fire_q && !stby_q) begin
          fire_d = 1'b1;
          start_d = 1'b1;
        end else if (!req_i.wdata[HMT_BIT_FIRE] && fire_q) begin
          fire_d = 1'b0;
          cancel_d = 1'b1;
        end
      end else if (mode_q == HMT_MODE_EDGE && !stby_q) begin
        if (trig_rise && !fire_q) begin
          fire_d = 1'b1;
          start_d = 1'b1;
        end else if (trig_rise && fire_q) begin
          fire_d = 1'b0;
          cancel_d = 1'b1;
        end
      end else if (mode_q == HMT_MODE_LEVEL && !stby_q) begin
        if (trig_rise && !fire_q) begin
          fire_d = 1'b1;
          start_d = 1'b1;
        end else if (trig_fall && fire_q) begin
          fire_d = 1'b0;
          cancel_d = 1'b1;
        end
      end
      if (routine_done_i && fire_q && !start_d && !cancel_d) begin
        fire_d = 1'b0;
        if (routine_mode) begin
          outcome_d = routine_fail_i;
        end
      end
    end
  end

  // drive source, drive level and read answer
  always_comb begin
    src_d = HMT_SRC_NONE;
    level_d = HMT_LEVEL_IDLE;
    if (!stby_q && !srst_q) begin
      unique case (mode_q)
        HMT_MODE_INT, HMT_MODE_EDGE, HMT_MODE_LEVEL: src_d = fire_q ? HMT_SRC_LIBRARY : HMT_SRC_NONE;
        HMT_MODE_PWM: src_d = analog_select_i ? HMT_SRC_ANALOG : HMT_SRC_PWM;
        HMT_MODE_AUDIO: src_d = HMT_SRC_AUDIO;
        HMT_MODE_LIVE: begin
          src_d = HMT_SRC_LIVE;
          level_d = live_value_signedness_i ? {1'b0, live_q} : {live_q[7], live_q};
        end
        HMT_MODE_DIAG: src_d = fire_q ? HMT_SRC_DIAG : HMT_SRC_NONE;
        HMT_MODE_CAL: src_d = fire_q ? HMT_SRC_CAL : HMT_SRC_NONE;
      endcase
    end
    rsp_d.valid = req_i.rd;
    rsp_d.data = HMT_RDATA_RST;
    if (req_i.rd) begin
      unique case (req_i.addr)
        HMT_ADDR_STATUS: rsp_d.data[HMT_BIT_OUTCOME] = outcome_q;
        HMT_ADDR_MODE: begin
          rsp_d.data[HMT_BIT_SRST] = srst_q;
          rsp_d.data[HMT_BIT_STBY] = stby_q;
          rsp_d.data[HMT_MODE_MSB:0] = mode_q;
        end
        HMT_ADDR_LIVE: rsp_d.data = live_q;
        HMT_ADDR_FIRE: rsp_d.data[HMT_BIT_FIRE] = fire_q;
        default: rsp_d.data = HMT_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      srst_q <= HMT_SRST_RST;
      stby_q <= HMT_STBY_RST;
      mode_q <= HMT_MODE_INT;
      live_q <= HMT_LIVE_RST;
      fire_q <= 1'b0;
      outcome_q <= 1'b0;
      start_o <= 1'b0;
      cancel_o <= 1'b0;
      drive_src_o <= HMT_SRC_NONE;
      drive_level_o <= HMT_LEVEL_IDLE;
      rsp_o <= '0;
    end else begin
      srst_q <= srst_d;
      stby_q <= stby_d;
      mode_q <= mode_d;
      live_q <= live_d;
      fire_q <= fire_d;
      outcome_q <= outcome_d;
      start_o <= start_d;
      cancel_o <= cancel_d;
      drive_src_o <= src_d;
      drive_level_o <= level_d;
      rsp_o <= rsp_d;
    end
  end

  always_comb begin
    fire_o = fire_q;
    standby_o = stby_q;
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic quiet;
  logic host_go;
  always_comb begin
    quiet = !srst_q && !req_i.wr && !routine_done_i && !stby_q;
    host_go = wr_fire && req_i.wdata[HMT_BIT_FIRE];
  end

  a_srst_defaults: assert property (srst_q |=> !fire_q && mode_q == HMT_MODE_INT && live_q == HMT_LIVE_RST)
    else $error("soft reset left a register off its default");
  a_srst_self_clear: assert property (srst_q |=> !srst_q)
    else $error("soft reset bit did not clear itself");
  a_stby_default: assert property (srst_q |=> stby_q ##1 drive_src_o == HMT_SRC_NONE)
    else $error("standby not restored or drive still active");
  a_int_fire_src: assert property ($rose(fire_q) && $past(mode_q) == HMT_MODE_INT |-> $past(host_go))
    else $error("internal trigger mode fired without a host write");
  a_edge_set: assert property (quiet && mode_q == HMT_MODE_EDGE && trig_rise && !fire_q |=> fire_q && start_o)
    else $error("rising edge did not set fire");
  a_edge_cancel: assert property (quiet && mode_q == HMT_MODE_EDGE && trig_rise && fire_q |=> !fire_q && cancel_o)
    else $error("second rising edge did not cancel");
  a_level_fall: assert property (quiet && mode_q == HMT_MODE_LEVEL && trig_fall && fire_q |=> !fire_q && cancel_o)
    else $error("falling trigger did not cancel");
  a_level_noop: assert property (quiet && mode_q == HMT_MODE_LEVEL && trig_fall && !fire_q |=> !cancel_o && !fire_q)
    else $error("redundant edge caused an action");
  a_pwm_src: assert property (!srst_q && !stby_q && mode_q == HMT_MODE_PWM |=> drive_src_o == ($past(analog_select_i) ? HMT_SRC_ANALOG : HMT_SRC_PWM))
    else $error("pin source not selected in mode 3");
  a_audio_src: assert property (!srst_q && !stby_q && mode_q == HMT_MODE_AUDIO |=> drive_src_o == HMT_SRC_AUDIO)
    else $error("audio source not selected in mode 4");
  a_live_signed: assert property (!srst_q && !stby_q && mode_q == HMT_MODE_LIVE && !live_value_signedness_i |=> drive_level_o == {$past(live_q[7]), $past(live_q)})
    else $error("live value not driven sign extended");
  a_live_unsigned: assert property (!srst_q && !stby_q && mode_q == HMT_MODE_LIVE && live_value_signedness_i |=> drive_level_o == {1'b0, $past(live_q)})
    else $error("live value not driven zero extended");
  a_diag_done: assert property (!srst_q && !req_i.wr && fire_q && mode_q == HMT_MODE_DIAG && routine_done_i |=> !fire_q && outcome_q == $past(routine_fail_i))
    else $error("diagnostic end not recorded");
  a_cal_done: assert property (!srst_q && !req_i.wr && fire_q && mode_q == HMT_MODE_CAL && routine_done_i |=> !fire_q ##1 !start_o)
    else $error("calibration did not self-clear fire");
  a_outcome_rc: assert property (rd_status && !srst_q && !routine_done_i ##1 rsp_o.valid |-> !outcome_q)
    else $error("outcome flag not cleared by read");
  a_reserved_zero: assert property (req_i.rd && req_i.addr == HMT_ADDR_MODE |=> rsp_o.valid && rsp_o.data[5:3] == 3'h0)
    else $error("reserved mode bits read nonzero");

  c_edge_cancel: cover property (mode_q == HMT_MODE_EDGE && trig_rise && fire_q);
  c_diag_fail: cover property (mode_q == HMT_MODE_DIAG && fire_q && routine_done_i && routine_fail_i);
  c_soft_reset: cover property (srst_q && fire_q);
  c_live_drive: cover property (drive_src_o == HMT_SRC_LIVE);
  c_level_hold: cover property (mode_q == HMT_MODE_LEVEL && trig_level && fire_q);
endmodule
`default_nettype wire

// ---- hmt_eng_model.sv ----
// routine engine model: answers each start that is not cancelled with a done pulse after a delay
// assumes one-cycle start and cancel pulses from the mode control block
`timescale 1ns/1ps
`default_nettype none
module hmt_eng_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // control from the block and the bench
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [7:0] delay_i,
  input wire logic fail_i,
  // completion
  output logic done_o,
  output logic fail_o
);
  int cnt;
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else begin
      done_o <= (cnt == 1) && !start_i && !cancel_i;
      // result line only means something beside done
      fail_o <= (cnt == 1) ? fail_i : ~fail_i;
      if (start_i) cnt <= int'(delay_i);
      else if (cancel_i) cnt <= 0;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ---- haptic_mode_trigger_control_tb.sv ----
// self-checking bench of the mode control block
// assumes the routine engine model answers every start that is not cancelled
`timescale 1ns/1ps
`default_nettype none
module haptic_mode_trigger_control_tb;
  import hmt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  hmt_req_s req = '0;
  hmt_rsp_s rsp;
  logic pin = 1'b0;
  logic asel = 1'b0;
  logic acen = 1'b0;
  logic uns = 1'b0;
  logic fail = 1'b0;
  logic done, efail, fire, start, cancel, stby;
  hmt_src_e src;
  logic [8:0] lvl;
  logic [7:0] v;
  logic [7:0] expq[$];
  logic [31:0] rng = 32'h00010cdf;
  int err_total = 0;
  int tests_run = 0;
  int n_start = 0;
  int n_cancel = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  hmt_mode_ctrl u_hmt_mode_ctrl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .req_i(req), .rsp_o(rsp), .trigger_input_pin_i(pin), .analog_select_i(asel),
    .ac_coupling_enable_i(acen), .live_value_signedness_i(uns),
    .routine_done_i(done), .routine_fail_i(efail), .fire_o(fire), .start_o(start),
    .cancel_o(cancel), .standby_o(stby), .drive_src_o(src), .drive_level_o(lvl));
  hmt_eng_model u_hmt_eng_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .start_i(start), .cancel_i(cancel), .delay_i(8'h14), .fail_i(fail),
    .done_o(done), .fail_o(efail));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
    wt(1);
  endtask
  task automatic pin_to(input logic l);
    @(negedge clk_sys_i);
    pin = l;
    wt(6);
  endtask
  task automatic run(input hmt_mode_e m, input logic f);
    fail = f;
    acc(1'b1, HMT_ADDR_MODE, {5'h00, m});
    acc(1'b1, HMT_ADDR_FIRE, 8'h01);
    wt(1);
    chk("source", {6'h00, (m == HMT_MODE_DIAG) ? HMT_SRC_DIAG : HMT_SRC_CAL}, {6'h00, src});
    wt(25);
    chk("fire", 9'h000, {8'h00, fire});
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // read answers are matched against the oldest note
  always @(posedge clk_sys_i) begin
    if (start === 1'b1) n_start++;
    if (cancel === 1'b1) n_cancel++;
    if (rsp.valid === 1'b1) begin
      if (expq.size() == 0) chk("read count", 9'h001, 9'h000);
      else chk("read data", {1'b0, expq.pop_front()}, {1'b0, rsp.data});
    end
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk("standby", 9'h001, {8'h00, stby});
    rd(HMT_ADDR_MODE, 8'h40);
    acc(1'b1, HMT_ADDR_MODE, 8'h3f);
    rd(HMT_ADDR_MODE, 8'h07);
    acc(1'b1, HMT_ADDR_MODE, 8'h00);
    chk("standby", 9'h000, {8'h00, stby});
    pin_to(1'b1);
    chk("fire", 9'h000, {8'h00, fire});
    pin_to(1'b0);
    acc(1'b1, HMT_ADDR_FIRE, 8'h01);
    chk("fire", 9'h001, {8'h00, fire});
    wt(1);
    chk("source", {6'h00, HMT_SRC_LIBRARY}, {6'h00, src});
    wt(25);
    chk("fire", 9'h000, {8'h00, fire});
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_EDGE});
    pin_to(1'b1);
    chk("fire", 9'h001, {8'h00, fire});
    pin_to(1'b0);
    pin_to(1'b1);
    chk("fire", 9'h000, {8'h00, fire});
    pin_to(1'b0);
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_LEVEL});
    pin_to(1'b1);
    chk("fire", 9'h001, {8'h00, fire});
    pin_to(1'b0);
    chk("fire", 9'h000, {8'h00, fire});
    acc(1'b1, HMT_ADDR_FIRE, 8'h01);
    pin_to(1'b1);
    chk("fire", 9'h001, {8'h00, fire});
    pin_to(1'b0);
    chk("fire", 9'h000, {8'h00, fire});
    run(HMT_MODE_DIAG, 1'b1);
    rd(HMT_ADDR_STATUS, 8'h08);
    rd(HMT_ADDR_STATUS, 8'h00);
    run(HMT_MODE_DIAG, 1'b1);
    // calibration inputs count as programmed before this fire
    run(HMT_MODE_CAL, 1'b0);
    rd(HMT_ADDR_STATUS, 8'h00);
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_PWM});
    wt(2);
    chk("source", {6'h00, HMT_SRC_PWM}, {6'h00, src});
    asel = 1'b1;
    wt(3);
    chk("source", {6'h00, HMT_SRC_ANALOG}, {6'h00, src});
    acen = 1'b1;
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_AUDIO});
    wt(2);
    chk("source", {6'h00, HMT_SRC_AUDIO}, {6'h00, src});
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_LIVE});
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      v = rng[7:0];
      uns = i[0];
      acc(1'b1, HMT_ADDR_LIVE, v);
      wt(2);
      rd(HMT_ADDR_LIVE, v);
      chk("level", uns ? {1'b0, v} : {v[7], v}, lvl);
    end
    acc(1'b1, HMT_ADDR_MODE, 8'h45);
    wt(2);
    chk("level", 9'h000, lvl);
    acc(1'b1, HMT_ADDR_MODE, {5'h00, HMT_MODE_EDGE});
    pin_to(1'b1);
    acc(1'b1, HMT_ADDR_MODE, 8'h80);
    wt(1);
    chk("fire", 9'h000, {8'h00, fire});
    chk("standby", 9'h001, {8'h00, stby});
    rd(HMT_ADDR_MODE, 8'h40);
    rd(HMT_ADDR_LIVE, 8'h00);
    pin_to(1'b0);
    chk("starts", 9'h008, 9'(n_start));
    chk("cancels", 9'h004, 9'(n_cancel));
    tally_and_finish();
  end
endmodule
`default_nettype wire
